// ===== rtl/chg_regs_pkg.sv
// Package: offsets, field positions, reset values and enumerations of the register slice
package chg_regs_pkg;
  // Register indices (are printed offsets byte addresses, all multiples of four? no)
  // Printed offsets are not all multiples of four, so they are indices; byte address = 4*index
  localparam logic [7:0] FAULT_MASK_IDX = 8'h14;
  localparam logic [7:0] CONV_CTRL_IDX = 8'h15;
  localparam logic [7:0] CHAN_OFF_IDX = 8'h16;
  localparam logic [7:0] IIN_HIGH_IDX = 8'h17;
  localparam logic [7:0] IIN_LOW_IDX = 8'h18;
  localparam logic [7:0] FAULT_FLAG_IDX = 8'h30;
  localparam logic [7:0] IRQ_STATUS_IDX = 8'h31;
  localparam logic [7:0] IRQ_ENABLE_IDX = 8'h32;
  localparam logic [7:0] SYS_CTRL_IDX = 8'h33;
  localparam int IDX_LSB = 2;
  // Reset values
  localparam logic [7:0] FAULT_MASK_RST = 8'h00;
  localparam logic [7:0] CONV_CTRL_RST = 8'h30;
  localparam logic [7:0] CHAN_OFF_RST = 8'h00;
  localparam logic [7:0] IIN_HIGH_RST = 8'h00;
  // Writable bit masks; all other bits read zero
  localparam logic [7:0] FAULT_MASK_WMASK = 8'hd8;
  localparam logic [7:0] CONV_CTRL_WMASK = 8'hf0;
  localparam logic [7:0] CHAN_OFF_WMASK = 8'he7;
  // Field positions
  localparam int BIT_OVP = 7;
  localparam int BIT_TSHUT = 6;
  localparam int BIT_TMR = 4;
  localparam int BIT_SHORT = 3;
  localparam int BIT_CONV_EN = 7;
  localparam int BIT_ONE_SHOT = 6;
  localparam int BIT_RES_HI = 5;
  localparam int BIT_RES_LO = 4;
  localparam int BIT_SYS_REG_RESET = 0;
  localparam int NUM_FAULTS = 4;
  localparam int NUM_CHANS = 8;
  // Conversion time per channel, in cycles, for resolution codes 00..11
  localparam logic [15:0] CONV_CYC_15B = 16'h0800;
  localparam logic [15:0] CONV_CYC_14B = 16'h0400;
  localparam logic [15:0] CONV_CYC_13B = 16'h0200;
  localparam logic [15:0] CONV_CYC_12B = 16'h0100;
  // Sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_CONV = 2'b01,
    SEQ_NEXT = 2'b10
  } seq_state_t;
endpackage

// ===== rtl/fault_edge_irq.sv
// Fault edge detectors, sticky fault flags and masked pulse generation
`timescale 1ns/1ps
`default_nettype none
module fault_edge_irq
  import chg_regs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic soft_clear,
  input wire logic [NUM_FAULTS-1:0] fault_in,
  input wire logic [NUM_FAULTS-1:0] mask,
  output logic [NUM_FAULTS-1:0] rise,
  output logic [NUM_FAULTS-1:0] pulse_req,
  output logic [NUM_FAULTS-1:0] flags
);
  logic [NUM_FAULTS-1:0] prev_r;
  logic [NUM_FAULTS-1:0] flag_r;
  // Rising edges; the mask only gates the pulse, never the flag
  genvar g;
  generate
    for (g = 0; g < NUM_FAULTS; g++) begin : g_fault
      assign rise[g] = fault_in[g] & ~prev_r[g];
      assign pulse_req[g] = rise[g] & ~mask[g];
    end
  endgenerate
  assign flags = flag_r;
  // Flags latch on edge; an edge in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= '0;
      flag_r <= '0;
    end else begin
      prev_r <= fault_in;
      flag_r <= (soft_clear ? '0 : flag_r) | rise;
    end
  end
endmodule // fault_edge_irq
`default_nettype wire

// ===== rtl/conv_sequencer.sv
// Channel sequencer: walks enabled channels, restarts on setting change
`timescale 1ns/1ps
`default_nettype none
module conv_sequencer
  import chg_regs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic one_shot,
  input wire logic [1:0] resolution,
  input wire logic [NUM_CHANS-1:0] chan_off,
  input wire logic restart,
  output logic [2:0] chan,
  output logic sample_strobe,
  output logic pass_done
);
  seq_state_t state_r;
  logic [2:0] chan_r;
  logic [15:0] cnt_r;
  logic [15:0] conv_cyc;
  logic [2:0] chan_inc;
  logic last_chan;
  logic any_on;
  assign conv_cyc = (resolution == 2'b00) ? CONV_CYC_15B :
                    (resolution == 2'b01) ? CONV_CYC_14B :
                    (resolution == 2'b10) ? CONV_CYC_13B : CONV_CYC_12B;
  assign chan_inc = chan_r + 3'h1;
  assign last_chan = (chan_r == 3'h7);
  assign any_on = ~&chan_off;
  assign chan = chan_r;
  // Skipped channels advance in one cycle without a strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= SEQ_IDLE;
      chan_r <= 3'h0;
      cnt_r <= 16'h0000;
      sample_strobe <= 1'b0;
      pass_done <= 1'b0;
    end else begin
      sample_strobe <= 1'b0;
      pass_done <= 1'b0;
      if (!enable || restart) begin
        state_r <= SEQ_IDLE;
        chan_r <= 3'h0;
        cnt_r <= 16'h0000;
      end else begin
        case (state_r)
          SEQ_IDLE: begin
            if (any_on) begin
              state_r <= SEQ_NEXT;
            end
          end
          SEQ_NEXT: begin
            if (chan_off[chan_r]) begin
              chan_r <= chan_inc;
              if (last_chan) begin
                pass_done <= 1'b1;
                state_r <= one_shot ? SEQ_IDLE : SEQ_NEXT;
              end
            end else begin
              cnt_r <= conv_cyc;
              state_r <= SEQ_CONV;
            end
          end
          SEQ_CONV: begin
            if (cnt_r == 16'h0001) begin
              sample_strobe <= 1'b1;
              chan_r <= chan_inc;
              state_r <= SEQ_NEXT;
              if (last_chan) begin
                pass_done <= 1'b1;
                state_r <= one_shot ? SEQ_IDLE : SEQ_NEXT;
              end
            end else begin
              cnt_r <= cnt_r - 16'h0001;
            end
          end
          default: state_r <= SEQ_IDLE;
        endcase
      end
    end
  end
endmodule // conv_sequencer
`default_nettype wire

// ===== rtl/charger_fault_mask_adc_ctrl_regs.sv
// Top: APB register slice for fault mask, converter control and input current result
//
// Contract
// - Mask bit 7 clear: overvoltage rising edge emits an interrupt pulse; set suppresses it.
// - Mask bit 6 clear: thermal shutdown rising edge emits pulse; set suppresses it.
// - Mask bit 4 clear: safety timer expiry rising edge emits pulse; set suppresses it.
// - Mask bit 3 clear: sense short rising edge emits pulse; set suppresses it.
// - Fault mask at 14h resets 00h; bits 5,2,1,0 read zero.
// - All reserved bits read zero and ignore writes.
// - Converter control at 15h resets to 30h.
// - Bit 7 enables converter; cleared by register reset and watchdog expiry.
// - Bit 6 chooses continuous (0) or one-shot (1) conversion; with 1 the walk idles one cycle after each pass, then starts another.
// - Bits 5:4 select resolution 15,14,13,12 bits for 00..11.
// - Channel disable register at 16h: a 1 skips that channel.
// - Battery voltage disable bit 4 is read-only; bit 3 reserved.
// - High byte bits 14..8 weigh 16384 mA down to 256 mA.
// - Fault flag register latches each fault edge independently of the mask.
`timescale 1ns/1ps
`default_nettype none
module charger_fault_mask_adc_ctrl_regs
  import chg_regs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic watchdog_expired,
  input wire logic input_overvoltage,
  input wire logic thermal_shutdown,
  input wire logic safety_timer_expired,
  input wire logic sense_short,
  input wire logic [15:0] input_current_sample,
  output logic fault_irq_pulse,
  output logic irq,
  output logic [NUM_CHANS-1:0] channel_off_vec,
  output logic [2:0] active_channel,
  output logic converter_enabled
);
  import chg_regs_pkg::*;

  // ************************************************************
  // Bus decode
  // ************************************************************
  logic [7:0] fault_mask_r;
  logic [7:0] conv_ctrl_r;
  logic [7:0] chan_off_r;
  logic [15:0] iin_result_r;
  logic [7:0] iin_low_shadow_r;
  logic [NUM_FAULTS-1:0] irq_status_r;
  logic [NUM_FAULTS-1:0] irq_enable_r;
  logic [7:0] idx;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic reg_reset_cmd;
  logic soft_clear;

  // Index from word address; bytes beyond the low lane are read as zero
  assign idx = paddr[IDX_LSB+7:IDX_LSB];
  assign mapped = (idx == FAULT_MASK_IDX) | (idx == CONV_CTRL_IDX) |
                  (idx == CHAN_OFF_IDX) | (idx == IIN_HIGH_IDX) |
                  (idx == IIN_LOW_IDX) | (idx == FAULT_FLAG_IDX) |
                  (idx == IRQ_STATUS_IDX) | (idx == IRQ_ENABLE_IDX) |
                  (idx == SYS_CTRL_IDX);
  assign wr_en = psel & penable & pwrite & mapped & pstrb[0] & ~pready;
  assign rd_en = psel & penable & ~pwrite & mapped & ~pready;
  // Register reset command is a write of one to the system control bit
  assign reg_reset_cmd = wr_en & (idx == SYS_CTRL_IDX) & pwdata[BIT_SYS_REG_RESET];
  assign soft_clear = reg_reset_cmd;

  // ************************************************************
  // Fault detection
  // ************************************************************
  logic [NUM_FAULTS-1:0] fault_vec;
  logic [NUM_FAULTS-1:0] mask_vec;
  logic [NUM_FAULTS-1:0] rise_vec;
  logic [NUM_FAULTS-1:0] pulse_vec;
  logic [NUM_FAULTS-1:0] flag_vec;
  logic [7:0] fault_flag_view;

  // Order: overvoltage, thermal, timer, short
  assign fault_vec = {input_overvoltage, thermal_shutdown, safety_timer_expired, sense_short};
  assign mask_vec = {fault_mask_r[BIT_OVP], fault_mask_r[BIT_TSHUT],
                     fault_mask_r[BIT_TMR], fault_mask_r[BIT_SHORT]};
  assign fault_flag_view = {flag_vec[3], flag_vec[2], 1'b0, flag_vec[1], flag_vec[0], 3'b000};

  fault_edge_irq u_fault (
    .pclk(pclk),
    .presetn(presetn),
    .soft_clear(soft_clear),
    .fault_in(fault_vec),
    .mask(mask_vec),
    .rise(rise_vec),
    .pulse_req(pulse_vec),
    .flags(flag_vec)
  );

  // ************************************************************
  // Control registers
  // ************************************************************
  logic [7:0] wbyte;
  logic setting_change;
  logic [7:0] conv_ctrl_nxt;
  assign wbyte = pwdata[7:0];
  assign conv_ctrl_nxt = wbyte & CONV_CTRL_WMASK;
  // Any change of enable, mode or resolution restarts the channel walk
  assign setting_change = wr_en & (idx == CONV_CTRL_IDX) & (conv_ctrl_nxt != conv_ctrl_r);

  // Writable bits only; reserved and read-only bits stay zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_mask_r <= FAULT_MASK_RST;
      conv_ctrl_r <= CONV_CTRL_RST;
      chan_off_r <= CHAN_OFF_RST;
      irq_enable_r <= '0;
    end else if (reg_reset_cmd) begin
      fault_mask_r <= FAULT_MASK_RST;
      conv_ctrl_r <= CONV_CTRL_RST;
      chan_off_r <= CHAN_OFF_RST;
      irq_enable_r <= '0;
    end else begin
      if (wr_en && idx == FAULT_MASK_IDX) begin
        fault_mask_r <= wbyte & FAULT_MASK_WMASK;
      end
      if (wr_en && idx == CONV_CTRL_IDX) begin
        conv_ctrl_r <= conv_ctrl_nxt;
      end
      if (watchdog_expired) begin
        conv_ctrl_r[BIT_CONV_EN] <= 1'b0;
      end
      if (wr_en && idx == CHAN_OFF_IDX) begin
        chan_off_r <= wbyte & CHAN_OFF_WMASK;
      end
      if (wr_en && idx == IRQ_ENABLE_IDX) begin
        irq_enable_r <= wbyte[NUM_FAULTS-1:0];
      end
    end
  end

  // ************************************************************
  // Sequencer and result capture
  // ************************************************************
  logic [2:0] seq_chan;
  logic seq_strobe;
  logic seq_done;
  conv_sequencer u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .enable(conv_ctrl_r[BIT_CONV_EN]),
    .one_shot(conv_ctrl_r[BIT_ONE_SHOT]),
    .resolution(conv_ctrl_r[BIT_RES_HI:BIT_RES_LO]),
    .chan_off(chan_off_r),
    .restart(setting_change),
    .chan(seq_chan),
    .sample_strobe(seq_strobe),
    .pass_done()
  );
  // Channel 7 is input current; captured on the strobe that ends channel 6, when seq_chan already reads 7; whole, so both bytes share one conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iin_result_r <= {IIN_HIGH_RST, 8'h00};
    end else if (reg_reset_cmd) begin
      iin_result_r <= {IIN_HIGH_RST, 8'h00};
    end else if (seq_strobe && seq_chan == 3'h7) begin
      iin_result_r <= input_current_sample;
    end
  end
  // Reading the high byte freezes the low byte for the following read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iin_low_shadow_r <= 8'h00;
    end else if (rd_en && idx == IIN_HIGH_IDX) begin
      iin_low_shadow_r <= iin_result_r[7:0];
    end
  end

  // ************************************************************
  // Interrupt status
  // ************************************************************
  logic status_rd;
  assign status_rd = rd_en & (idx == IRQ_STATUS_IDX);
  // Sticky; an edge in the reading cycle survives the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_r <= '0;
    end else begin
      irq_status_r <= (status_rd ? '0 : irq_status_r) | rise_vec;
    end
  end

  // ************************************************************
  // Read mux and outputs
  // ************************************************************
  logic [7:0] rd_byte;
  assign rd_byte = (idx == FAULT_MASK_IDX) ? fault_mask_r :
                   (idx == CONV_CTRL_IDX) ? conv_ctrl_r :
                   (idx == CHAN_OFF_IDX) ? chan_off_r :
                   (idx == IIN_HIGH_IDX) ? iin_result_r[15:8] :
                   (idx == IIN_LOW_IDX) ? iin_low_shadow_r :
                   (idx == FAULT_FLAG_IDX) ? fault_flag_view :
                   (idx == IRQ_STATUS_IDX) ? {4'h0, irq_status_r} :
                   (idx == IRQ_ENABLE_IDX) ? {4'h0, irq_enable_r} : 8'h00;

  // One wait state: answer lands the cycle after the access phase starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      prdata <= (rd_en) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // Pulse and level outputs are registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_irq_pulse <= 1'b0;
      irq <= 1'b0;
      channel_off_vec <= '0;
      active_channel <= 3'h0;
      converter_enabled <= 1'b0;
    end else begin
      fault_irq_pulse <= |pulse_vec;
      irq <= |(irq_status_r & irq_enable_r);
      channel_off_vec <= chan_off_r;
      active_channel <= seq_chan;
      converter_enabled <= conv_ctrl_r[BIT_CONV_EN];
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_ovp_pulse;
    @(posedge pclk) disable iff (!presetn)
      (rise_vec[3] && !fault_mask_r[BIT_OVP]) |=> fault_irq_pulse;
  endproperty
  a_ovp_pulse: assert property (p_ovp_pulse) else $error("overvoltage pulse missing");
  property p_tshut_pulse;
    @(posedge pclk) disable iff (!presetn)
      (rise_vec[2] && !fault_mask_r[BIT_TSHUT]) |=> fault_irq_pulse;
  endproperty
  a_tshut_pulse: assert property (p_tshut_pulse) else $error("thermal pulse missing");
  property p_tmr_pulse;
    @(posedge pclk) disable iff (!presetn)
      (rise_vec[1] && !fault_mask_r[BIT_TMR]) |=> fault_irq_pulse;
  endproperty
  a_tmr_pulse: assert property (p_tmr_pulse) else $error("timer pulse missing");
  property p_short_pulse;
    @(posedge pclk) disable iff (!presetn)
      (rise_vec[0] && !fault_mask_r[BIT_SHORT]) |=> fault_irq_pulse;
  endproperty
  a_short_pulse: assert property (p_short_pulse) else $error("short pulse missing");
  property p_masked_quiet;
    @(posedge pclk) disable iff (!presetn)
      ((rise_vec & ~mask_vec) == '0) |=> !fault_irq_pulse;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("unexpected pulse");
  property p_mask_reserved;
    @(posedge pclk) disable iff (!presetn)
      (fault_mask_r & ~FAULT_MASK_WMASK) == 8'h00;
  endproperty
  a_mask_reserved: assert property (p_mask_reserved) else $error("mask reserved set");
  property p_chan_ro;
    @(posedge pclk) disable iff (!presetn)
      chan_off_r[4:3] == 2'b00;
  endproperty
  a_chan_ro: assert property (p_chan_ro) else $error("read-only channel bits set");
  property p_wdog_clear;
    @(posedge pclk) disable iff (!presetn)
      watchdog_expired |=> !conv_ctrl_r[BIT_CONV_EN] ##1 !converter_enabled;
  endproperty
  a_wdog_clear: assert property (p_wdog_clear) else $error("enable not cleared");
  property p_flag_latch;
    @(posedge pclk) disable iff (!presetn)
      (rise_vec[1] && !soft_clear) |=> flag_vec[1];
  endproperty
  a_flag_latch: assert property (p_flag_latch) else $error("timer flag not set");
endmodule // charger_fault_mask_adc_ctrl_regs
`default_nettype wire

// ===== verification/charger_fault_mask_adc_ctrl_regs_tb_top.sv
// Self-checking bench for the fault mask and converter control register slice
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Compare macro: counts every check, reports a mismatch at once
// ****************************************
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("FAIL %s expected %h seen %h", nm, e, g); end end
module charger_fault_mask_adc_ctrl_regs_tb_top;
  import chg_regs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pslverr, pready, wdog;
  logic fpulse, irq, conv_en, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r32;
  logic [3:0] flt;
  logic [15:0] sample;
  logic [7:0] chan_vec, rd, v, m;
  logic [2:0] act_ch;
  logic [31:0] seed = 32'hcd163565;
  int err_count, checks_done, cnt;
  // Register indices, reset values and writable bits, in the same order
  logic [7:0] ri[4] = '{8'h14, 8'h15, 8'h16, 8'h17};
  logic [7:0] rv[4] = '{8'h00, 8'h30, 8'h00, 8'h00};
  logic [7:0] wm[4] = '{8'hd8, 8'hf0, 8'he7, 8'h00};

  charger_fault_mask_adc_ctrl_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .watchdog_expired(wdog),
    .input_overvoltage(flt[3]), .thermal_shutdown(flt[2]), .safety_timer_expired(flt[1]),
    .sense_short(flt[0]), .input_current_sample(sample), .fault_irq_pulse(fpulse),
    .irq(irq), .channel_off_vec(chan_vec), .active_channel(act_ch),
    .converter_enabled(conv_en));

  // Free-running bus clock, 25 ns period
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Repeatable pseudo-random source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Readback of a written value: only writable bits survive
  function automatic logic [7:0] exp_rb(input int i, input logic [7:0] w);
    return w & wm[i];
  endfunction

  // One APB transfer; the slave's answer time is not assumed, only bounded
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      err_count++;
      $display("FAIL pready expected 1 seen timeout");
    end
    @(posedge pclk);
  endtask

  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under this span
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    wrap_up();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    wdog = 1'b0;
    flt = 4'h0;
    sample = 16'h0000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ri[i], 8'h00);
      `CHK("reset value", rv[i], rd)
    end
    done("reset values");
    // All ones first, then random data, into the four registers at 14h..17h
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 2; k++) begin
        r32 = rnd();
        v = k ? r32[7:0] : 8'hff;
        apb(1'b1, ri[i], v);
        apb(1'b0, ri[i], 8'h00);
        if (i != 3) `CHK("readback", exp_rb(i, v), rd)
      end
    end
    r32 = rnd();
    apb(1'b1, 8'h16, r32[7:0]);
    repeat (2) @(posedge pclk);
    `CHK("channel off vector", r32[7:0] & 8'he7, chan_vec)
    apb(1'b0, 8'h20, 8'h00);
    `CHK("unmapped error", 1'b1, err)
    `CHK("unmapped data", 8'h00, rd)
    done("access kinds");
    // Each fault edge, unmasked then masked
    apb(1'b1, 8'h32, 8'h0f);
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 2; k++) begin
        r32 = rnd();
        m = k ? (r32[7:0] | 8'hd8) : (r32[7:0] & 8'h27);
        apb(1'b1, 8'h14, m);
        apb(1'b0, 8'h31, 8'h00);
        flt[3-i] <= 1'b1;
        cnt = 0;
        repeat (5) begin
          @(posedge pclk);
          if (fpulse === 1'b1) cnt++;
        end
        `CHK("fault pulse count", k ? 0 : 1, cnt)
        if (k == 0) begin
          `CHK("irq level", 1'b1, irq)
          apb(1'b0, 8'h31, 8'h00);
          `CHK("irq status", 8'h01 << (3 - i), rd)
          `CHK("irq cleared", 1'b0, irq)
        end
        flt[3-i] <= 1'b0;
        repeat (2) @(posedge pclk);
      end
    end
    apb(1'b0, 8'h30, 8'h00);
    `CHK("fault flags", 8'hd8, rd)
    done("fault pulses");
    // Watchdog expiry drops only the enable bit
    r32 = rnd();
    v = 8'h80 | (r32[7:0] & 8'h70);
    apb(1'b1, 8'h15, v);
    repeat (2) @(posedge pclk);
    `CHK("converter enabled", 1'b1, conv_en)
    wdog <= 1'b1;
    @(posedge pclk);
    wdog <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK("enable after watchdog", 1'b0, conv_en)
    apb(1'b0, 8'h15, 8'h00);
    `CHK("control after watchdog", v & 8'h70, rd)
    done("watchdog");
    // Full pass at the shortest resolution, then both result bytes and the read-only high byte
    r32 = rnd();
    sample <= r32[15:0];
    apb(1'b1, 8'h16, 8'h00);
    apb(1'b1, 8'h15, 8'hb0);
    repeat (3000) @(posedge pclk);
    apb(1'b0, 8'h17, 8'h00);
    `CHK("result high", sample[15:8], rd)
    apb(1'b0, 8'h18, 8'h00);
    `CHK("result low", sample[7:0], rd)
    apb(1'b1, 8'h17, ~sample[15:8]);
    apb(1'b0, 8'h17, 8'h00);
    `CHK("result read only", sample[15:8], rd)
    done("conversion result");
    // Register reset command restores the control registers and clears the flags; interrupt status is kept
    apb(1'b1, 8'h33, 8'h01);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, ri[i], 8'h00);
      `CHK("value after command", rv[i], rd)
    end
    apb(1'b0, 8'h30, 8'h00);
    `CHK("flags after command", 8'h00, rd)
    repeat (2) @(posedge pclk);
    `CHK("channel after command", 3'h0, act_ch)
    done("register reset");
    wrap_up();
  end
endmodule // charger_fault_mask_adc_ctrl_regs_tb_top
`default_nettype wire
